// *** src/vectored_interrupt_controller.sv ***
// Vectored interrupt controller: flags, masks, priority and the
// entry / return sequencer that steers the processor core.
// Assumes an APB master on i_ref_clk, same-clock peripheral event
// pulses and core strobes, and asynchronous pin inputs.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module vectored_interrupt_controller (
    input  wire logic              i_ref_clk,        // Core clock
    input  wire logic              i_rst_n,          // Sync reset, low
    input  wire logic              i_psel,           // APB select
    input  wire logic              i_penable,        // APB enable
    input  wire logic              i_pwrite,         // APB direction
    input  wire logic [vic_pkg::APB_AW-1:0] i_paddr, // APB byte address
    input  wire logic [31:0]       i_pwdata,         // APB write data
    input  wire logic [3:0]        i_pstrb,          // APB byte strobes
    output logic      [31:0]       o_prdata,         // APB read data
    output logic                   o_pready,         // APB ready
    output logic                   o_pslverr,        // APB error
    input  wire logic              i_ext_req0_pin,   // External request
    input  wire logic [7:0]        i_port_b_pins,    // Port B levels
    input  wire logic [2:0]        i_port_a_pins,    // Port A 7, 6, 3
    input  wire logic [10:0]       i_pin_alt_mask,   // Alt function on
    input  wire logic [8:0]        i_periph_event,   // Source 2..10 pulses
    input  wire logic              i_instr_boundary, // Instruction done
    input  wire logic              i_return_instr,   // Return executed
    output logic                   o_irq_pending,    // Request to core
    output logic                   o_push_pc,        // Push counter
    output logic                   o_pop_pc,         // Pop counter
    output logic                   o_vector_load,    // Load vector pulse
    output logic [vic_pkg::PC_W-1:0] o_vector_addr,  // Vector address
    output logic                   o_jump_busy,      // Vector jump runs
    output logic                   o_gie             // Global enable
);
    import vic_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        vic_state_t               state;
        logic [2:0]               cnt;
        logic [3:0]               sel;
        logic                     vec_load;
        logic [PC_W-1:0]          vec_addr;
        logic                     gie;
        logic [7:0]               gmask;
        logic [7:0]               tmask;
        logic [7:0]               pmask;
        logic [1:0]               sense;
        logic [NUM_SRC-1:0]       flag;
        logic                     ext_prev;
        logic [NUM_PINS-1:0]      pins_prev;
        logic [31:0]              prdata;
    } vic_regs_t;

    vic_regs_t s_q;
    vic_regs_t s_d;

    logic [NUM_PINS:0]    pins_s;
    logic                 ext_s;
    logic [NUM_PINS-1:0]  pins_now;
    logic [NUM_SRC-1:0]   set_ev;
    logic [NUM_SRC-1:0]   clr_sw;
    logic [NUM_SRC-1:0]   clr_hw;
    logic [NUM_SRC-1:0]   en;
    logic [NUM_SRC-1:0]   req;
    logic [NUM_SRC-1:0]   act;
    logic                 sel_any;
    logic [3:0]           sel_idx;
    logic                 accept;
    logic                 ret_take;
    logic                 ext_edge;
    logic [NUM_PINS-1:0]  chg;
    logic [7:0]           idx;
    logic                 hit;
    logic                 wr;
    logic                 setup;
    logic [7:0]           wd;
    logic [7:0]           rd;

    // ------------------------------------------------------------------
    // Pin synchronisers and priority encoder
    // ------------------------------------------------------------------
    vic_sync2 #(
        .W (NUM_PINS + 1)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_async   ({i_ext_req0_pin, i_port_a_pins, i_port_b_pins}),
        .o_sync    (pins_s)
    );

    assign ext_s    = pins_s[NUM_PINS];
    assign pins_now = pins_s[NUM_PINS-1:0];

    vic_prio_enc #(
        .N (NUM_SRC)
    ) u_prio (
        .i_req (act),
        .o_any (sel_any),
        .o_idx (sel_idx)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign idx       = i_paddr[9:2];
    assign hit       = (idx >= IDX_TIMER_FLAG) && (idx <= IDX_STATUS);
    assign setup     = i_psel && !i_penable;
    assign wr        = i_psel && i_penable && i_pwrite && i_pstrb[0] && hit;
    assign wd        = i_pwdata[7:0];
    assign o_pready  = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && !hit;

    // ------------------------------------------------------------------
    // Event detection, enables and requests
    // ------------------------------------------------------------------
    always_comb begin
        unique case (s_q.sense)
            SENSE_ANY:  ext_edge = ext_s ^ s_q.ext_prev;
            SENSE_FALL: ext_edge = s_q.ext_prev && !ext_s;
            SENSE_RISE: ext_edge = ext_s && !s_q.ext_prev;
            SENSE_LOW:  ext_edge = 1'b0;
        endcase
    end

    assign chg = (pins_now ^ s_q.pins_prev) & ~i_pin_alt_mask;

    always_comb begin
        set_ev = '0;
        set_ev[SRC_EXT0] = ext_edge;
        set_ev[SRC_PIN]  = (|chg[3:0] && s_q.gmask[GMASK_DIG_BIT])
                        || (|chg[10:4] && s_q.gmask[GMASK_ANA_BIT]);
        set_ev[NUM_SRC-1:SRC_FIRST_EVT] = i_periph_event;
    end

    always_comb begin
        en = '0;
        en[SRC_EXT0] = s_q.gmask[GMASK_EXT0_BIT];
        en[SRC_PIN]  = s_q.gmask[GMASK_ANA_BIT] || s_q.gmask[GMASK_DIG_BIT];
        en[2] = s_q.tmask[TIM_CMPA_BIT];
        en[3] = s_q.tmask[TIM_CMPB_BIT];
        en[4] = s_q.tmask[TIM_OVF1_BIT];
        en[5] = s_q.tmask[TIM_OVF0_BIT];
        en[NUM_SRC-1:SRC_SER_START] = s_q.pmask[4:0];
    end

    always_comb begin
        req = s_q.flag;
        if (s_q.sense == SENSE_LOW) begin
            req[SRC_EXT0] = !ext_s;
        end
    end

    assign act = req & en & {NUM_SRC{s_q.gie}};

    // Entry waits for the core's instruction boundary
    assign accept   = (s_q.state == ST_IDLE) && i_instr_boundary
                   && sel_any;
    assign ret_take = (s_q.state == ST_IDLE) && i_return_instr && !accept;

    // ------------------------------------------------------------------
    // Write-one-to-clear and read mux
    // ------------------------------------------------------------------
    always_comb begin
        clr_sw = '0;
        if (wr) begin
            unique case (idx)
                IDX_GEN_FLAG: begin
                    clr_sw[SRC_EXT0] = wd[GFLAG_EXT0_BIT];
                    clr_sw[SRC_PIN]  = wd[GFLAG_PIN_BIT];
                end
                IDX_TIMER_FLAG: begin
                    clr_sw[2] = wd[TIM_CMPA_BIT];
                    clr_sw[3] = wd[TIM_CMPB_BIT];
                    clr_sw[4] = wd[TIM_OVF1_BIT];
                    clr_sw[5] = wd[TIM_OVF0_BIT];
                end
                IDX_PERIPH_FLAG: begin
                    clr_sw[NUM_SRC-1:SRC_SER_START] = wd[4:0];
                end
                default: begin
                    clr_sw = '0;
                end
            endcase
        end
    end

    always_comb begin
        rd = REG_RESET;
        unique case (idx)
            IDX_GEN_MASK:    rd = s_q.gmask;
            IDX_TIMER_MASK:  rd = s_q.tmask;
            IDX_PERIPH_MASK: rd = s_q.pmask;
            IDX_EXT_SENSE:   rd = {6'h00, s_q.sense};
            IDX_STATUS:      rd = {s_q.gie, 7'h00};
            IDX_GEN_FLAG: begin
                rd[GFLAG_EXT0_BIT] = s_q.flag[SRC_EXT0];
                rd[GFLAG_PIN_BIT]  = s_q.flag[SRC_PIN];
            end
            IDX_TIMER_FLAG: begin
                rd[TIM_CMPA_BIT] = s_q.flag[2];
                rd[TIM_CMPB_BIT] = s_q.flag[3];
                rd[TIM_OVF1_BIT] = s_q.flag[4];
                rd[TIM_OVF0_BIT] = s_q.flag[5];
            end
            IDX_PERIPH_FLAG: rd = {3'h0, s_q.flag[NUM_SRC-1:SRC_SER_START]};
            default:         rd = REG_RESET;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d           = s_q;
        s_d.vec_load  = 1'b0;
        s_d.ext_prev  = ext_s;
        s_d.pins_prev = pins_now;
        clr_hw        = '0;
        if (setup) begin
            s_d.prdata = {24'h000000, rd};
        end
        if (wr) begin
            unique case (idx)
                IDX_GEN_MASK:    s_d.gmask = wd & GEN_MASK_WMASK;
                IDX_TIMER_MASK:  s_d.tmask = wd & TIMER_WMASK;
                IDX_PERIPH_MASK: s_d.pmask = wd & PERIPH_WMASK;
                IDX_EXT_SENSE:   s_d.sense = wd[1:0];
                IDX_STATUS:      s_d.gie   = wd[STATUS_GIE_BIT];
                default:         s_d.gie   = s_q.gie;
            endcase
        end
        // Only the enable bit is kept; the status word is left alone
        unique case (s_q.state)
            ST_RESET_VEC: begin
                s_d.vec_load = 1'b1;
                s_d.vec_addr = VEC_RESET;
                s_d.cnt      = JUMP_CYCLES;
                s_d.state    = ST_JUMP;
            end
            ST_IDLE: begin
                if (accept) begin
                    s_d.gie   = 1'b0;
                    s_d.sel   = sel_idx;
                    s_d.cnt   = ENTRY_CYCLES - 3'h1;
                    s_d.state = ST_ENTRY;
                end else if (ret_take) begin
                    s_d.cnt   = RETURN_CYCLES - 3'h1;
                    s_d.state = ST_RETURN;
                end
            end
            ST_ENTRY: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.vec_load = 1'b1;
                    s_d.vec_addr = vec_of(s_q.sel);
                    clr_hw[s_q.sel] = 1'b1;
                    s_d.cnt   = JUMP_CYCLES;
                    s_d.state = ST_JUMP;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_JUMP: begin
                s_d.cnt = s_q.cnt - 3'h1;
                if (s_q.cnt == 3'h1) begin
                    s_d.state = ST_IDLE;
                end
            end
            ST_RETURN: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.gie   = 1'b1;
                    s_d.state = ST_HOLD;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_HOLD: begin
                if (i_instr_boundary) begin
                    s_d.state = ST_IDLE;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
        // A new event wins over either clear in the same cycle
        s_d.flag = (s_q.flag & ~clr_sw & ~clr_hw) | set_ev;
        if (s_d.sense == SENSE_LOW) begin
            s_d.flag[SRC_EXT0] = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_prdata      = s_q.prdata;
    assign o_irq_pending = sel_any;
    assign o_push_pc     = (s_q.state == ST_ENTRY);
    assign o_pop_pc      = (s_q.state == ST_RETURN);
    assign o_vector_load = s_q.vec_load;
    assign o_vector_addr = s_q.vec_addr;
    assign o_jump_busy   = (s_q.state == ST_JUMP);
    assign o_gie         = s_q.gie;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    AST_MASK_RSVD: assert property (
        (s_q.gmask & ~GEN_MASK_WMASK) == 8'h00)
        else $error("reserved mask bits set");

    AST_GIE_CLEAR: assert property (
        accept |=> !o_gie && o_push_pc)
        else $error("global enable not cleared on entry");

    AST_ENTRY_LEN: assert property (
        accept |=> o_push_pc [*4] ##1 (o_vector_load && !o_push_pc))
        else $error("entry not four cycles");

    AST_JUMP_LEN: assert property (
        $rose(o_jump_busy) |-> o_jump_busy [*2] ##1 !o_jump_busy)
        else $error("vector jump not two cycles");

    AST_RET_LEN: assert property (
        ret_take |=> o_pop_pc [*4] ##1 (!o_pop_pc && o_gie))
        else $error("return not four cycles or enable not set");

    AST_HOLD_ONE: assert property (
        (s_q.state == ST_HOLD) |=> !o_push_pc)
        else $error("entry right after return");

    AST_ENABLE_GATE: assert property (
        $rose(o_push_pc) |-> $past(o_gie) && $past(en[sel_idx]))
        else $error("entry without enables");

    AST_PRIORITY: assert property (
        accept |-> (act & ((11'h001 << sel_idx) - 11'h001)) == 11'h000)
        else $error("lower vector not preferred");

    AST_VEC_ADDR: assert property (
        o_vector_load |-> o_vector_addr <= VEC_LAST
            && (o_vector_addr == VEC_RESET
                || o_vector_addr == vec_of($past(s_q.sel))))
        else $error("wrong vector address");

    AST_SET_WINS: assert property (
        (set_ev[SRC_PIN] || (set_ev[2] && !clr_hw[2])) |=>
            s_q.flag[SRC_PIN] || s_q.flag[2])
        else $error("event lost");

    AST_LEVEL_FLAG: assert property (
        (s_q.sense == SENSE_LOW) |-> !s_q.flag[SRC_EXT0])
        else $error("level mode holds a flag");
endmodule

// *** src/vic_pkg.sv ***
// Constants, register map and state encoding of the interrupt controller.
// Assumes a 200 MHz core clock and an APB bus with 32-bit data.
package vic_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NUM_SRC       = 11;
    localparam int          PC_W          = 10;
    localparam int          APB_AW        = 10;
    localparam int          NUM_PINS      = 11;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0]  IDX_TIMER_FLAG  = 8'h38;
    localparam logic [7:0]  IDX_TIMER_MASK  = 8'h39;
    localparam logic [7:0]  IDX_GEN_FLAG    = 8'h3a;
    localparam logic [7:0]  IDX_GEN_MASK    = 8'h3b;
    localparam logic [7:0]  IDX_PERIPH_FLAG = 8'h3c;
    localparam logic [7:0]  IDX_PERIPH_MASK = 8'h3d;
    localparam logic [7:0]  IDX_EXT_SENSE   = 8'h3e;
    localparam logic [7:0]  IDX_STATUS      = 8'h3f;

    // ------------------------------------------------------------------
    // Field positions, writable masks and reset values
    // ------------------------------------------------------------------
    localparam int          GMASK_EXT0_BIT  = 6;
    localparam int          GMASK_ANA_BIT   = 5;
    localparam int          GMASK_DIG_BIT   = 4;
    localparam logic [7:0]  GEN_MASK_WMASK  = 8'h70;
    localparam int          GFLAG_EXT0_BIT  = 6;
    localparam int          GFLAG_PIN_BIT   = 5;
    localparam int          TIM_CMPA_BIT    = 6;
    localparam int          TIM_CMPB_BIT    = 5;
    localparam int          TIM_OVF1_BIT    = 2;
    localparam int          TIM_OVF0_BIT    = 1;
    localparam logic [7:0]  TIMER_WMASK     = 8'h66;
    localparam logic [7:0]  PERIPH_WMASK    = 8'h1f;
    localparam int          STATUS_GIE_BIT  = 7;
    localparam logic [7:0]  REG_RESET       = 8'h00;

    // ------------------------------------------------------------------
    // Sources, by priority; vector address is index plus one
    // ------------------------------------------------------------------
    localparam int          SRC_EXT0      = 0;
    localparam int          SRC_PIN       = 1;
    localparam int          SRC_FIRST_EVT = 2;
    localparam int          SRC_SER_START = 6;
    localparam logic [9:0]  VEC_RESET     = 10'h000;
    localparam logic [9:0]  VEC_LAST      = 10'h00b;

    // ------------------------------------------------------------------
    // External request sense codes
    // ------------------------------------------------------------------
    localparam logic [1:0]  SENSE_LOW     = 2'h0;
    localparam logic [1:0]  SENSE_ANY     = 2'h1;
    localparam logic [1:0]  SENSE_FALL    = 2'h2;
    localparam logic [1:0]  SENSE_RISE    = 2'h3;

    // ------------------------------------------------------------------
    // Sequencer timing in core clock cycles
    // ------------------------------------------------------------------
    localparam logic [2:0]  ENTRY_CYCLES  = 3'h4;
    localparam logic [2:0]  RETURN_CYCLES = 3'h4;
    localparam logic [2:0]  JUMP_CYCLES   = 3'h2;

    typedef enum logic [2:0] {
        ST_RESET_VEC,
        ST_IDLE,
        ST_ENTRY,
        ST_JUMP,
        ST_RETURN,
        ST_HOLD
    } vic_state_t;

    function automatic logic [9:0] vec_of(input logic [3:0] idx);
        vec_of = 10'(idx) + 10'h001;
    endfunction

endpackage

// *** src/vic_sync2.sv ***
// Two-stage synchroniser for a vector of pin levels.
// Assumes the inputs are asynchronous to i_ref_clk.
`timescale 1ns/1ps
module vic_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk, // Core clock
    input  wire logic         i_rst_n,   // Synchronous reset, low
    input  wire logic [W-1:0] i_async,   // Raw pin levels
    output logic      [W-1:0] o_sync     // Synchronised levels
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule

// *** src/vic_prio_enc.sv ***
// Fixed priority encoder: the lowest set bit wins.
// Assumes a same-clock request vector; purely combinational.
`timescale 1ns/1ps
module vic_prio_enc #(
    parameter int N = 11
) (
    input  wire logic [N-1:0] i_req, // Active requests
    output logic              o_any, // Any request
    output logic [3:0]        o_idx  // Winning index
);
    always_comb begin
        o_any = 1'b0;
        o_idx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (i_req[i]) begin
                o_any = 1'b1;
                o_idx = 4'(i);
            end
        end
    end
endmodule

// *** verification/core_model.sv ***
// Core stand-in: instruction boundary level and return strobe.
// Assumes the bench holds i_ret_req high for one cycle per return.
`timescale 1ns/1ps
module core_model (
    input  wire logic i_ref_clk,        // Core clock
    input  wire logic i_rst_n,          // Sync reset, low
    input  wire logic i_multi_cycle,    // Long instruction runs
    input  wire logic i_ret_req,        // Execute a return
    output logic      o_instr_boundary, // At boundary
    output logic      o_return_instr    // One-cycle return pulse
);
    logic ret_q;
    assign o_instr_boundary = !i_multi_cycle;
    assign o_return_instr   = ret_q;
    always_ff @(posedge i_ref_clk) begin
        ret_q <= i_rst_n & i_ret_req & !ret_q;
    end
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the vectored interrupt controller.
// Assumes the core stand-in and the package from the design side.
`timescale 1ns/1ps
module tb_top;
    import vic_pkg::*;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        multi, ret_req, bnd, return_from_handler_instr, irq, push, pop, vload, jbusy;
    logic        gie, ext_pin;
    logic [7:0]  pb;
    logic [9:0]  paddr, vaddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  evt;
    int          num_errors = 0;
    int          n_compared = 0;

    vectored_interrupt_controller DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_ext_req0_pin(ext_pin),
        .i_port_b_pins(pb), .i_port_a_pins(3'h0),
        .i_pin_alt_mask(11'h000), .i_periph_event(evt),
        .i_instr_boundary(bnd), .i_return_instr(return_from_handler_instr),
        .o_irq_pending(irq), .o_push_pc(push), .o_pop_pc(pop),
        .o_vector_load(vload), .o_vector_addr(vaddr),
        .o_jump_busy(jbusy), .o_gie(gie));
    core_model core (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_multi_cycle(multi), .i_ret_req(ret_req),
        .o_instr_boundary(bnd), .o_return_instr(return_from_handler_instr));

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bound(input int w);
        if (w >= 40) begin
            num_errors++;
            $display("CHECK FAILED wait expected done seen timeout");
            print_verdict();
        end
    endtask
    // ----------------------------------------------------------------
    // APB master
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 40);
        bound(w);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(what, rd, {24'h0, exp});
    endtask
    task automatic pulse(input logic [8:0] v);
        @(posedge clk);
        evt <= v;
        @(posedge clk);
        evt <= 9'h000;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        int w;
        w = 0;
        while (vload !== 1'b1 && w < 40) begin
            @(negedge clk);
            w++;
        end
        bound(w);
        chk("reset_vec", vaddr, VEC_RESET);
        $display("test reset done");
    endtask
    task automatic test_regs();
        rchk("gmask_rst", IDX_GEN_MASK, REG_RESET);
        apb(1'b1, IDX_GEN_MASK, 8'hff);
        rchk("gmask_rw", IDX_GEN_MASK, 8'h70);
        apb(1'b1, IDX_GEN_MASK, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_rd", rd, 32'h0);
        $display("test regs done");
    endtask
    task automatic test_flags();
        pulse(9'h1ff);
        rchk("tflag", IDX_TIMER_FLAG, 8'h66);
        rchk("pflag", IDX_PERIPH_FLAG, 8'h1f);
        apb(1'b1, IDX_PERIPH_FLAG, 8'h01);
        rchk("pflag_w1c", IDX_PERIPH_FLAG, 8'h1e);
        apb(1'b1, IDX_TIMER_FLAG, 8'h00);
        rchk("tflag_w0", IDX_TIMER_FLAG, 8'h66);
        $display("test flags done");
    endtask
    task automatic serve(input logic [9:0] vec);
        int w;
        int n;
        w = 0;
        n = 0;
        while (push !== 1'b1 && w < 40) begin
            @(negedge clk);
            w++;
        end
        bound(w);
        while (push === 1'b1 && n < 8) begin
            chk("gie_entry", gie, 1'b0);
            @(negedge clk);
            n++;
        end
        chk("push_len", n, 4);
        chk("vaddr", vaddr, vec);
        chk("jump", {vload, jbusy}, 2'b11);
        @(negedge clk);
        chk("jump2", jbusy, 1'b1);
        @(negedge clk);
        chk("jump_end", jbusy, 1'b0);
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        w = 0;
        n = 0;
        while (pop !== 1'b1 && w < 40) begin
            @(negedge clk);
            w++;
        end
        bound(w);
        while (pop === 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk("pop_len", n, 4);
        chk("gie_ret", gie, 1'b1);
        @(negedge clk);
        chk("hold", push, 1'b0);
    endtask
    task automatic test_service();
        pulse(9'h010);
        apb(1'b1, IDX_TIMER_MASK, 8'h66);
        apb(1'b1, IDX_PERIPH_MASK, 8'h1f);
        chk("irq_gie0", irq, 1'b0);
        multi <= 1'b1;
        apb(1'b1, IDX_STATUS, 8'h80);
        repeat (6) begin
            @(negedge clk);
            chk("no_entry", push, 1'b0);
        end
        chk("irq_gie1", irq, 1'b1);
        @(posedge clk);
        multi <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            serve(10'(k + 3));
        end
        rchk("tflag_clr", IDX_TIMER_FLAG, 8'h00);
        rchk("pflag_clr", IDX_PERIPH_FLAG, 8'h00);
        $display("test service done");
    endtask

    task automatic test_pins();
        multi <= 1'b1;
        apb(1'b1, IDX_GEN_MASK, 8'h10);
        pb <= 8'h01;
        repeat (4) @(posedge clk);
        rchk("pin_dig", IDX_GEN_FLAG, 8'h20);
        apb(1'b1, IDX_GEN_FLAG, 8'h20);
        pb <= 8'h11;
        repeat (4) @(posedge clk);
        rchk("pin_ana_off", IDX_GEN_FLAG, 8'h00);
        apb(1'b1, IDX_EXT_SENSE, {6'h00, SENSE_FALL});
        ext_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rchk("ext_fall", IDX_GEN_FLAG, 8'h40);
        apb(1'b1, IDX_EXT_SENSE, {6'h00, SENSE_LOW});
        rchk("ext_level", IDX_GEN_FLAG, 8'h00);
        apb(1'b1, IDX_GEN_MASK, 8'h40);
        apb(1'b1, IDX_STATUS, 8'h80);
        @(negedge clk);
        chk("level_on", irq, 1'b1);
        @(posedge clk);
        ext_pin <= 1'b1;
        repeat (4) @(negedge clk);
        chk("level_off", irq, 1'b0);
        $display("test pins done");
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, multi, ret_req} = 5'h00;
        paddr = 10'h000;
        pwdata = 32'h0;
        evt = 9'h000;
        ext_pin = 1'b1;
        pb = 8'h00;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        test_reset();
        test_regs();
        test_flags();
        test_service();
        test_pins();
        print_verdict();
    end
endmodule
